// *** hw/qtig_table.v ***
// Behaviour
// - each table byte is driven on the low eight data lines
// - upper eight data lines always carry zero for table entries
// - minimum logic supply entry returns 23, BCD volts and tenths
// - maximum logic supply entry returns 36, BCD volts and tenths
// - typical word program timeout exponent returns 09, microseconds
// - typical full buffer write timeout exponent returns 0a, microseconds
// - typical block erase timeout exponent returns 0a, milliseconds
// - typical and maximum chip erase entries return 00, not offered
// - maximum word program factor exponent returns 01
// - maximum buffer write factor exponent returns 02
// - maximum block erase factor exponent returns 02
// - device size exponent is 1a for smallest density, else 1b
// - interface capability returns 01 then 00, sixteen-bit only
// - write buffer size returns 0a then 00, 1024 bytes
// - region count is 02 for parameter layouts, 01 for symmetric
// - first region descriptor: count minus one low, size/256 high
// - second region descriptor at 31 uses the same layout
// - four reserved bytes from 35 return the filler value
`timescale 1ns/1ns
`include "qtig_defines.vh"

module qtig_table #(
   parameter [1:0] DENSITY = `QTIG_DEN_512M,
   parameter [1:0] LAYOUT  = `QTIG_LAY_TOP,
   parameter       ADDR_W  = 8
) (
   // clock and reset
   input  wire              i_clk_sys,
   input  wire              i_rst,
   // query mode from the surrounding command logic
   input  wire              i_query_mode,
   // host bus pins
   input  wire [ADDR_W-1:0] i_addr,
   input  wire              i_ce_n,
   input  wire              i_oe_n,
   // data pins
   output wire [15:0]       o_dq,
   output wire              o_dq_oe_n,
   // status
   output wire              o_hit,
   output wire              o_cfg_err
);

   // synchronised host pins
   wire [ADDR_W-1:0] addr_s;
   wire              ce_n_s;
   wire              oe_n_s;

   // output stage
   reg  [7:0]        data_lo_q;
   reg  [7:0]        data_lo_d;
   reg  [7:0]        data_hi_q;
   reg               drive_q;
   reg               drive_d;
   reg               hit_q;
   reg               hit_d;

   // variant resolution
   wire [1:0]        den_eff;
   wire [1:0]        lay_eff;
   wire [63:0]       rgn_bytes;
   wire [7:0]        size_byte;
   wire [7:0]        rgn_cnt_byte;
   wire              read_req;
   wire              in_window;

   qtig_sync #(
      .WIDTH (ADDR_W + 2)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_async   ({i_addr, i_ce_n, i_oe_n}),
      .o_sync    ({addr_s, ce_n_s, oe_n_s})
   );

   // true when the word address falls inside 1b..38
   function in_range;
      input [ADDR_W-1:0] a;
      reg   [ADDR_W-1:0] lo;
      reg   [ADDR_W-1:0] hi;
      begin
         lo = `QTIG_OFS_FIRST;
         hi = `QTIG_OFS_LAST;
         in_range = (a >= lo) && (a <= hi);
      end
   endfunction

   // true when the address sits inside a four byte descriptor
   function in_block;
      input [ADDR_W-1:0] a;
      input [7:0]        base;
      reg   [ADDR_W-1:0] b;
      begin
         b = base;
         in_block = (a >= b) && (a < b + `QTIG_RGN_LEN);
      end
   endfunction

   // region descriptor table for a density and layout
   function [63:0] rgn_table;
      input [1:0] den;
      input [1:0] lay;
      begin
         rgn_table = `QTIG_RGN_LARGE_SYM;
         case (den)
            `QTIG_DEN_512M: begin
               case (lay)
                  `QTIG_LAY_TOP:    rgn_table = `QTIG_RGN_512M_TOP;
                  `QTIG_LAY_BOTTOM: rgn_table = `QTIG_RGN_512M_BOTTOM;
                  default:          rgn_table = `QTIG_RGN_512M_SYM;
               endcase
            end
            `QTIG_DEN_1G: begin
               case (lay)
                  `QTIG_LAY_TOP:    rgn_table = `QTIG_RGN_1G_TOP;
                  `QTIG_LAY_BOTTOM: rgn_table = `QTIG_RGN_1G_BOTTOM;
                  default:          rgn_table = `QTIG_RGN_LARGE_SYM;
               endcase
            end
            default: rgn_table = `QTIG_RGN_LARGE_SYM;
         endcase
      end
   endfunction

   // pick one byte of the eight region descriptor bytes
   function [7:0] rgn_pick;
      input [63:0]       tbl;
      input [ADDR_W-1:0] a;
      reg   [ADDR_W-1:0] rel;
      reg   [2:0]        idx;
      begin
         rel = a - `QTIG_OFS_RGN1;
         idx = rel[2:0];
         rgn_pick = tbl[{idx, 3'h0} +: 8];
      end
   endfunction

   // the larger density ships only as a symmetric part
   assign o_cfg_err = (DENSITY == `QTIG_DEN_2G) && (LAYOUT != `QTIG_LAY_SYM) ||
                      (DENSITY > `QTIG_DEN_2G) || (LAYOUT > `QTIG_LAY_SYM);

   assign den_eff = (DENSITY > `QTIG_DEN_2G) ? `QTIG_DEN_2G : DENSITY;
   assign lay_eff = (o_cfg_err) ? `QTIG_LAY_SYM : LAYOUT;

   assign size_byte = (den_eff == `QTIG_DEN_512M) ? `QTIG_VAL_SIZE_SMALL :
                      `QTIG_VAL_SIZE_LARGE;

   assign rgn_cnt_byte = (lay_eff == `QTIG_LAY_SYM) ? `QTIG_VAL_RGN_CNT_SYM :
                         `QTIG_VAL_RGN_CNT_PAR;

   assign rgn_bytes = rgn_table(den_eff, lay_eff);

   assign read_req  = i_query_mode && !ce_n_s && !oe_n_s;
   assign in_window = in_range(addr_s);

   // table lookup
   always @* begin
      data_lo_d = `QTIG_VAL_RSVD;
      hit_d     = in_window;
      drive_d   = read_req && in_window;
      case (addr_s)
         `QTIG_OFS_LS_MIN: begin
            data_lo_d = `QTIG_VAL_LS_MIN;
         end
         `QTIG_OFS_LS_MAX: begin
            data_lo_d = `QTIG_VAL_LS_MAX;
         end
         `QTIG_OFS_PS_MIN: begin
            data_lo_d = `QTIG_VAL_PS_MIN;
         end
         `QTIG_OFS_PS_MAX: begin
            data_lo_d = `QTIG_VAL_PS_MAX;
         end
         `QTIG_OFS_WP_TYP: begin
            data_lo_d = `QTIG_VAL_WP_TYP;
         end
         `QTIG_OFS_BW_TYP: begin
            data_lo_d = `QTIG_VAL_BW_TYP;
         end
         `QTIG_OFS_BE_TYP: begin
            data_lo_d = `QTIG_VAL_BE_TYP;
         end
         `QTIG_OFS_CE_TYP: begin
            data_lo_d = `QTIG_VAL_CE_TYP;
         end
         `QTIG_OFS_CE_MAX: begin
            data_lo_d = `QTIG_VAL_CE_MAX;
         end
         `QTIG_OFS_WP_MAX: begin
            data_lo_d = `QTIG_VAL_WP_MAX;
         end
         `QTIG_OFS_BW_MAX: begin
            data_lo_d = `QTIG_VAL_BW_MAX;
         end
         `QTIG_OFS_BE_MAX: begin
            data_lo_d = `QTIG_VAL_BE_MAX;
         end
         `QTIG_OFS_SIZE: begin
            data_lo_d = size_byte;
         end
         `QTIG_OFS_IFC_LO: begin
            data_lo_d = `QTIG_VAL_IFC_LO;
         end
         `QTIG_OFS_IFC_HI: begin
            data_lo_d = `QTIG_VAL_IFC_HI;
         end
         `QTIG_OFS_WBUF_LO: begin
            data_lo_d = `QTIG_VAL_WBUF_LO;
         end
         `QTIG_OFS_WBUF_HI: begin
            data_lo_d = `QTIG_VAL_WBUF_HI;
         end
         `QTIG_OFS_RGN_CNT: begin
            data_lo_d = rgn_cnt_byte;
         end
         default: begin
            if (in_block(addr_s, `QTIG_OFS_RGN1)) begin
               data_lo_d = rgn_pick(rgn_bytes, addr_s);
            end else if (in_block(addr_s, `QTIG_OFS_RGN2)) begin
               data_lo_d = rgn_pick(rgn_bytes, addr_s);
            end else if (in_block(addr_s, `QTIG_OFS_RGN_RSVD)) begin
               data_lo_d = `QTIG_VAL_RSVD;
            end else begin
               data_lo_d = `QTIG_VAL_RSVD;
            end
         end
      endcase
   end

   // registered data and enable
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         data_lo_q <= 8'h00;
         data_hi_q <= 8'h00;
         drive_q   <= 1'b0;
         hit_q     <= 1'b0;
      end else begin
         data_lo_q <= data_lo_d;
         data_hi_q <= `QTIG_VAL_UPPER;
         drive_q   <= drive_d;
         hit_q     <= hit_d;
      end
   end

   assign o_dq      = {data_hi_q, data_lo_q};
   assign o_dq_oe_n = !drive_q;
   assign o_hit     = hit_q;

endmodule // qtig_table

// *** hw/qtig_defines.vh ***
`ifndef QTIG_DEFINES_VH
`define QTIG_DEFINES_VH

// word offsets of the interface and geometry entries
`define QTIG_OFS_FIRST        8'h1b
`define QTIG_OFS_LAST         8'h38
`define QTIG_OFS_LS_MIN       8'h1b
`define QTIG_OFS_LS_MAX       8'h1c
`define QTIG_OFS_PS_MIN       8'h1d
`define QTIG_OFS_PS_MAX       8'h1e
`define QTIG_OFS_WP_TYP       8'h1f
`define QTIG_OFS_BW_TYP       8'h20
`define QTIG_OFS_BE_TYP       8'h21
`define QTIG_OFS_CE_TYP       8'h22
`define QTIG_OFS_WP_MAX       8'h23
`define QTIG_OFS_BW_MAX       8'h24
`define QTIG_OFS_BE_MAX       8'h25
`define QTIG_OFS_CE_MAX       8'h26
`define QTIG_OFS_SIZE         8'h27
`define QTIG_OFS_IFC_LO       8'h28
`define QTIG_OFS_IFC_HI       8'h29
`define QTIG_OFS_WBUF_LO      8'h2a
`define QTIG_OFS_WBUF_HI      8'h2b
`define QTIG_OFS_RGN_CNT      8'h2c
`define QTIG_OFS_RGN1         8'h2d
`define QTIG_OFS_RGN2         8'h31
`define QTIG_OFS_RGN_RSVD     8'h35

// fixed entry values
`define QTIG_VAL_LS_MIN       8'h23
`define QTIG_VAL_LS_MAX       8'h36
`define QTIG_VAL_PS_MIN       8'h85
`define QTIG_VAL_PS_MAX       8'h95
`define QTIG_VAL_WP_TYP       8'h09
`define QTIG_VAL_BW_TYP       8'h0a
`define QTIG_VAL_BE_TYP       8'h0a
`define QTIG_VAL_CE_TYP       8'h00
`define QTIG_VAL_WP_MAX       8'h01
`define QTIG_VAL_BW_MAX       8'h02
`define QTIG_VAL_BE_MAX       8'h02
`define QTIG_VAL_CE_MAX       8'h00
`define QTIG_VAL_IFC_LO       8'h01
`define QTIG_VAL_IFC_HI       8'h00
`define QTIG_VAL_WBUF_LO      8'h0a
`define QTIG_VAL_WBUF_HI      8'h00
`define QTIG_VAL_RSVD         8'h00
`define QTIG_VAL_UPPER        8'h00
`define QTIG_VAL_SIZE_SMALL   8'h1a
`define QTIG_VAL_SIZE_LARGE   8'h1b
`define QTIG_VAL_RGN_CNT_PAR  8'h02
`define QTIG_VAL_RGN_CNT_SYM  8'h01

// variant codes
`define QTIG_DEN_512M         2'h0
`define QTIG_DEN_1G           2'h1
`define QTIG_DEN_2G           2'h2
`define QTIG_LAY_TOP          2'h0
`define QTIG_LAY_BOTTOM       2'h1
`define QTIG_LAY_SYM          2'h2

// region descriptors, offset 2d in bits 7:0 up to offset 34 in bits 63:56
`define QTIG_RGN_512M_TOP     64'h0080_0003_0200_01fe
`define QTIG_RGN_512M_BOTTOM  64'h0200_01fe_0080_0003
`define QTIG_RGN_512M_SYM     64'h0000_0000_0200_01ff
`define QTIG_RGN_1G_TOP       64'h0080_0003_0200_03fe
`define QTIG_RGN_1G_BOTTOM    64'h0200_03fe_0080_0003
`define QTIG_RGN_LARGE_SYM    64'h0000_0000_0200_03ff
`define QTIG_RGN_BYTES        4'h8
`define QTIG_RGN_LEN          8'h04

`endif

// *** hw/qtig_sync.v ***
`timescale 1ns/1ns

module qtig_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             i_clk_sys,
   input  wire             i_rst,
   // asynchronous side
   input  wire [WIDTH-1:0] i_async,
   // synchronised side
   output wire [WIDTH-1:0] o_sync
);

   genvar g;

   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= i_async[g];
               sync_q <= meta_q;
            end
         end
         assign o_sync[g] = sync_q;
      end
   endgenerate

endmodule // qtig_sync

// *** test/qtig_host.sv ***
`timescale 1ns/1ns

module qtig_host (
   // clock
   input  wire       i_clk_sys,
   // host bus pins
   output reg  [7:0] o_addr,
   output reg        o_ce_n,
   output reg        o_oe_n
);
   initial begin
      o_addr = 8'h00;
      o_ce_n = 1'b1;
      o_oe_n = 1'b1;
   end

   // one bus cycle, held until the registered answer has landed
   task access(input [7:0] a, input ce_n, input oe_n);
      begin
         @(negedge i_clk_sys);
         o_addr = a;
         o_ce_n = ce_n;
         o_oe_n = oe_n;
         repeat (3) @(posedge i_clk_sys);
         @(negedge i_clk_sys);
      end
   endtask
endmodule // qtig_host

// *** test/qtig_table_sva.sv ***
`timescale 1ns/1ns

module qtig_table_sva #(
   parameter [1:0] DENSITY = 2'h0,
   parameter [1:0] LAYOUT  = 2'h0,
   parameter       ADDR_W  = 8
) (
   input  wire              i_clk_sys,
   input  wire              i_rst,
   input  wire              i_query_mode,
   input  wire [ADDR_W-1:0] i_addr,
   input  wire              i_ce_n,
   input  wire              i_oe_n,
   input  wire [15:0]       o_dq,
   input  wire              o_dq_oe_n,
   input  wire              o_hit,
   input  wire              o_cfg_err
);
   reg  [ADDR_W-1:0] a1_q;
   reg  [ADDR_W-1:0] a2_q;
   reg  [ADDR_W-1:0] a3_q;
   reg  [1:0]        since_q;
   wire              ok;
   wire              in_rng;
   wire [7:0]        lo;

   // address as seen by the output register, and reset settling
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         a1_q    <= {ADDR_W{1'b0}};
         a2_q    <= {ADDR_W{1'b0}};
         a3_q    <= {ADDR_W{1'b0}};
         since_q <= 2'h0;
      end else begin
         a1_q    <= i_addr;
         a2_q    <= a1_q;
         a3_q    <= a2_q;
         since_q <= (since_q == 2'h3) ? since_q : since_q + 2'h1;
      end
   end
   assign ok     = (since_q == 2'h3);
   assign in_rng = (a3_q >= 8'h1b) && (a3_q <= 8'h38);
   assign lo     = o_dq[7:0];

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   a_upper_zero: assert property (o_dq[15:8] == 8'h00)
      else $error("upper data byte not zero");
   a_drive_cause: assert property (ok && !o_dq_oe_n |-> $past(i_query_mode) &&
      $past(i_ce_n, 3) == 1'b0 && $past(i_oe_n, 3) == 1'b0 && in_rng)
      else $error("data driven without a query read");
   a_read_drives: assert property (ok && $past(i_query_mode) && $past(i_ce_n, 3) == 1'b0 &&
      $past(i_oe_n, 3) == 1'b0 && in_rng |-> !o_dq_oe_n && o_hit)
      else $error("query read not driven");
   a_oe_release: assert property (ok && $rose(i_oe_n) |-> ##3 o_dq_oe_n)
      else $error("drive not released after oe");
   a_ls_min: assert property (ok && a3_q == 8'h1b |-> lo == 8'h23)
      else $error("logic supply minimum wrong");
   a_ls_max: assert property (ok && a3_q == 8'h1c |-> lo == 8'h36)
      else $error("logic supply maximum wrong");
   a_ps_range: assert property (ok && (a3_q == 8'h1d || a3_q == 8'h1e) |->
      lo == ((a3_q == 8'h1d) ? 8'h85 : 8'h95))
      else $error("programming supply entry wrong");
   a_chip_erase: assert property (ok && (a3_q == 8'h22 || a3_q == 8'h26) |-> lo == 8'h00)
      else $error("chip erase entry not zero");
   a_size_exp: assert property (ok && a3_q == 8'h27 |->
      lo == ((DENSITY == 2'h0) ? 8'h1a : 8'h1b))
      else $error("device size exponent wrong");
   a_rgn_count: assert property (ok && a3_q == 8'h2c |->
      lo == ((LAYOUT == 2'h2 || o_cfg_err) ? 8'h01 : 8'h02))
      else $error("region count wrong");
   a_rsvd_zero: assert property (ok && a3_q >= 8'h35 && a3_q <= 8'h38 |-> lo == 8'h00)
      else $error("reserved region byte not zero");
   a_cfg_legal: assert property (o_cfg_err == ((DENSITY == 2'h2 && LAYOUT != 2'h2) ||
      DENSITY == 2'h3 || LAYOUT == 2'h3))
      else $error("variant error flag wrong");

   c_drive: cover property (ok && !o_dq_oe_n);
   c_count: cover property (ok && a3_q == 8'h2c && !o_dq_oe_n);
   c_release: cover property (ok && $rose(o_dq_oe_n));
endmodule // qtig_table_sva

bind qtig_table qtig_table_sva #(.DENSITY(DENSITY), .LAYOUT(LAYOUT), .ADDR_W(ADDR_W)) u_sva (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_query_mode(i_query_mode), .i_addr(i_addr),
   .i_ce_n(i_ce_n), .i_oe_n(i_oe_n), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_hit(o_hit),
   .o_cfg_err(o_cfg_err));

// *** test/tb_query_table_interface_geometry.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
   compares = compares + 1; \
   if ((g) !== (e)) begin \
      bad_count = bad_count + 1; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
   end \
end

module tb_query_table_interface_geometry;
   reg                i_clk_sys;
   reg                i_rst;
   reg                mode;
   wire [7:0]         addr;
   wire               ce_n;
   wire               oe_n;
   wire [15:0]        dq [0:2];
   wire               dq_oe_n [0:2];
   wire               hit [0:2];
   wire               cfg_err [0:2];
   integer            bad_count;
   integer            compares;
   integer            v;
   integer            k;
   reg  [7:0]         a;
   reg  [7:0]         e;
   localparam [95:0]  SYS = 96'h00_02_02_01_00_0a_0a_09_95_85_36_23;
   localparam [191:0] RGN = {64'h0000_0000_0200_03ff, 64'h0200_03fe_0080_0003,
                             64'h0080_0003_0200_01fe};

   always #5 i_clk_sys = ~i_clk_sys;

   qtig_host u_host (.i_clk_sys(i_clk_sys), .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n));

   // variants: 512Mb top, 1Gb bottom, 1Gb symmetric
   genvar g;
   for (g = 0; g < 3; g = g + 1) begin : gen_v
      qtig_table #(
         .DENSITY((g == 0) ? 2'h0 : 2'h1),
         .LAYOUT ((g == 0) ? 2'h0 : ((g == 1) ? 2'h1 : 2'h2)),
         .ADDR_W (8)
      ) u_dut (
         .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_query_mode(mode), .i_addr(addr),
         .i_ce_n(ce_n), .i_oe_n(oe_n), .o_dq(dq[g]), .o_dq_oe_n(dq_oe_n[g]), .o_hit(hit[g]),
         .o_cfg_err(cfg_err[g]));
   end

   function [7:0] exp_byte(input integer vv, input [7:0] aa);
      begin
         exp_byte = 8'h00;
         if (aa >= 8'h1b && aa <= 8'h26)
            exp_byte = SYS[(aa - 8'h1b) * 8 +: 8];
         else if (aa == 8'h27)
            exp_byte = (vv == 0) ? 8'h1a : 8'h1b;
         else if (aa == 8'h28)
            exp_byte = 8'h01;
         else if (aa == 8'h2a)
            exp_byte = 8'h0a;
         else if (aa == 8'h2c)
            exp_byte = (vv == 2) ? 8'h01 : 8'h02;
         else if (aa >= 8'h2d && aa <= 8'h34)
            exp_byte = RGN[vv * 64 + (aa - 8'h2d) * 8 +: 8];
      end
   endfunction

   task report_and_stop;
      begin
         $display("compares=%0d bad_count=%0d", compares, bad_count);
         if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   initial begin
      i_clk_sys = 1'b0;
      bad_count = 0;
      compares = 0;
      i_rst = 1'b1;
      mode = 1'b0;
      repeat (3) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_rst = 1'b0;
      mode = 1'b1;
      // back-to-back reads across the window and one past each end
      for (k = 8'h1a; k <= 8'h39; k = k + 1) begin
         a = k[7:0];
         u_host.access(a, 1'b0, 1'b0);
         for (v = 0; v < 3; v = v + 1) begin
            e = exp_byte(v, a);
            `CHK("upper", 8'h00, dq[v][15:8])
            `CHK("oe_n", (a >= 8'h1b && a <= 8'h38) ? 1'b0 : 1'b1, dq_oe_n[v])
            `CHK("hit", (a >= 8'h1b && a <= 8'h38) ? 1'b1 : 1'b0, hit[v])
            `CHK("cfg", 1'b0, cfg_err[v])
            if (a < 8'h21)
               `CHK("sys", e, dq[v][7:0])
            else if (a < 8'h27)
               `CHK("tmo", e, dq[v][7:0])
            else if (a < 8'h2d)
               `CHK("geo", e, dq[v][7:0])
            else
               `CHK("rgn", e, dq[v][7:0])
         end
      end
      // no mode, no chip enable, no output enable
      for (k = 0; k < 3; k = k + 1) begin
         mode = (k != 0);
         u_host.access(8'h2c, k == 1, k == 2);
         `CHK("refuse", 1'b1, dq_oe_n[0])
      end
      u_host.access(8'h2c, 1'b0, 1'b0);
      `CHK("again", 8'h02, dq[1][7:0])
      // reset in mid-read clears the output stage at once
      i_rst = 1'b1;
      @(negedge i_clk_sys);
      `CHK("rst_oe", 1'b1, dq_oe_n[1])
      `CHK("rst_dq", 16'h0000, dq[1])
      `CHK("rst_hit", 1'b0, hit[1])
      repeat (2) @(negedge i_clk_sys);
      i_rst = 1'b0;
      u_host.access(8'h2c, 1'b0, 1'b0);
      `CHK("rst_read", 8'h02, dq[1][7:0])
      `CHK("rst_drv", 1'b0, dq_oe_n[1])
      u_host.access(8'hd3, 1'b1, 1'b1);
      `CHK("idle", 1'b1, dq_oe_n[2])
      `CHK("idle_hit", 1'b0, hit[2])
      report_and_stop;
   end
endmodule // tb_query_table_interface_geometry
